// >>> msi_sink_model.sv
// Purpose: Receiver of interrupt write requests.
// Assumes: Acknowledges promptly or after four cycles when slow is set.
// Notes: Counts and keeps the last accepted request.
`timescale 1ns/1ns
module msi_sink_model
    import ntb_link_msi_pkg::*;
(
    input  wire logic     mclk,
    input  wire logic     rst_n,
    input  wire msi_req_s msi_req,
    input  wire logic     msi_req_valid,
    input  wire logic     slow,
    output logic          msi_req_ack,
    output msi_req_s      last_req,
    output int            req_count
);
    logic [2:0] wait_q;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wait_q      <= 3'h0;
            msi_req_ack <= 1'h0;
            last_req    <= '0;
            req_count   <= 0;
        end else if (msi_req_valid && msi_req_ack) begin
            last_req    <= msi_req;
            req_count   <= req_count + 1;
            msi_req_ack <= 1'h0;
            wait_q      <= 3'h0;
        end else if (msi_req_valid) begin
            if (!slow || wait_q == 3'h4) begin
                msi_req_ack <= 1'h1;
            end else begin
                wait_q <= wait_q + 3'h1;
            end
        end
    end
endmodule

// >>> ntb_link_msi_asserts.sv
// Purpose: Checker for the link and message interrupt registers.
// Assumes: Single clock mclk, asynchronous active low rst_n.
// Notes: Bound to the register block below.
`timescale 1ns/1ns
module link_regs_checker
    import ntb_link_msi_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic [1:0]  bresp,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0]  rresp,
    input wire logic        rvalid,
    input wire logic        rready,
    input wire logic        irq_event,
    input wire msi_req_s    msi_req,
    input wire logic        msi_req_valid,
    input wire logic        msi_req_ack,
    input wire logic        msi_enable
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    rd_answer_a: assert property (arvalid && arready |=> rvalid && !arready)
        else $error("read not answered one cycle after take");
    rd_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
        else $error("read data dropped before rready");
    rd_err_a: assert property (rvalid && rresp == RESP_SLVERR |-> rdata == 32'h0)
        else $error("error read returned nonzero data");
    wr_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped before bready");
    wr_resp_a: assert property (bvalid |-> bresp == RESP_OKAY || bresp == RESP_SLVERR)
        else $error("write response code unexpected");
    aw_take_a: assert property (awvalid && awready |=> !awready)
        else $error("second write address taken while busy");
    msi_hold_a: assert property (msi_req_valid && !msi_req_ack |=> msi_req_valid && $stable(msi_req))
        else $error("interrupt request changed before acknowledge");
    msi_wide_a: assert property (
        msi_req_valid |-> msi_req.wide == (msi_req.msg_addr_high != 32'h0))
        else $error("wide flag does not match upper address");
    msi_fmt_a: assert property (
        msi_req_valid |-> msi_req.msg_addr_low[1:0] == 2'h0 && msi_req.data[31:16] == 16'h0)
        else $error("interrupt address or data format wrong");
    irq_send_a: assert property (
        irq_event && msi_enable && !msi_req_valid ##1 msi_enable [*2] |-> ##[0:1] msi_req_valid)
        else $error("enabled event did not raise a request");
    irq_quiet_a: assert property (
        !msi_enable && !$past(msi_enable) && !msi_req_valid |=> !msi_req_valid)
        else $error("request raised while interrupts disabled");
endmodule

bind ntb_link_msi_cap_regs link_regs_checker u_link_regs_checker (
    .mclk(mclk), .rst_n(rst_n), .awvalid(awvalid), .awready(awready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .irq_event(irq_event), .msi_req(msi_req),
    .msi_req_valid(msi_req_valid), .msi_req_ack(msi_req_ack), .msi_enable(msi_enable)
);

// >>> ntb_link_msi_cap_regs.sv
// Purpose: Link capability, link control and status, message interrupt and bridge header registers.
// Assumes: AXI4-Lite slave on mclk; event and acknowledge come from logic on the same clock.
// Notes: One write and one read may be outstanding at a time.
`timescale 1ns/1ns
module ntb_link_msi_cap_regs
    import ntb_link_msi_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic [2:0]        awprot,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic [2:0]        arprot,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    input  wire logic              irq_event,
    output msi_req_s               msi_req,
    output logic                   msi_req_valid,
    input  wire logic              msi_req_ack,
    output logic                   msi_enable,
    output logic [1:0]             power_state_ctrl
);

    typedef enum logic [0:0] {
        MSI_IDLE,
        MSI_SEND
    } msi_state_e;

    // Write channel state.
    logic                 awready_q;
    logic                 wready_q;
    logic                 aw_held_q;
    logic [IDX_W-1:0]     aw_idx_q;
    logic                 w_held_q;
    logic [31:0]          wdata_q;
    logic [3:0]           wstrb_q;
    logic                 bvalid_q;
    logic [1:0]           bresp_q;

    // Read channel state.
    logic                 arready_q;
    logic                 rvalid_q;
    logic [31:0]          rdata_q;
    logic [1:0]           rresp_q;

    // Stored register fields.
    logic [1:0]           power_ctrl_q;
    logic                 refclk_cfg_q;
    logic                 long_sync_q;
    logic                 msi_enable_q;
    logic [29:0]          addr_dw_q;
    logic [31:0]          addr_high_q;
    logic [15:0]          payload_q;
    bridge_cap_s          bridge_q;

    // Interrupt message sender.
    msi_state_e           msi_state_q;
    logic                 pending_q;
    logic                 msi_valid_q;
    msi_req_s             msi_req_q;

    // Decoded helpers.
    logic                 aw_take;
    logic                 w_take;
    logic                 do_write;
    logic                 ar_take;
    logic [IDX_W-1:0]     ar_idx;
    logic [31:0]          cur_word;
    logic                 cur_hit;
    logic [31:0]          new_word;
    link_ctrl_s           new_ctrl;
    msi_cap_s             new_msi;
    logic [31:0]          rd_word;
    logic                 rd_hit;
    logic                 launch;

    link_cap_s            link_cap_v;
    link_ctrl_s           link_ctrl_v;
    link_status_s         link_status_v;
    msi_cap_s             msi_cap_v;

    // Builds the hardwired and stored fields of the link capability, link control, link status and interrupt capability registers.
    always_comb begin
        link_cap_v                      = '0;
        link_cap_v.max_speed_code       = SPEED_CODE;          // RULE_01
        link_cap_v.max_width_code       = WIDTH_CODE;          // RULE_02
        link_cap_v.power_state_support  = POWER_SUPPORT_CODE;  // RULE_03
        link_cap_v.light_sleep_exit_lat = EXIT_LAT_CODE;       // RULE_04
        link_cap_v.deep_sleep_exit_lat  = EXIT_LAT_CODE;       // RULE_04
        link_cap_v.port_index           = PORT_INDEX_CODE;     // RULE_05

        link_ctrl_v                     = '0;                  // RULE_07
        link_ctrl_v.power_state_ctrl    = power_ctrl_q;        // RULE_06
        link_ctrl_v.shared_refclk_cfg   = refclk_cfg_q;        // RULE_08
        link_ctrl_v.long_sync_bit       = long_sync_q;         // RULE_08

        link_status_v                    = '0;                 // RULE_10
        link_status_v.current_speed_code = SPEED_CODE;         // RULE_09
        link_status_v.current_width_code = WIDTH_CODE;         // RULE_09

        msi_cap_v                       = '0;
        msi_cap_v.cap_identifier        = MSI_CAP_ID;          // RULE_11
        msi_cap_v.next_cap_pointer      = MSI_NEXT_PTR;        // RULE_11
        msi_cap_v.msi_enable            = msi_enable_q;        // RULE_12
        msi_cap_v.msg_count_capable     = MSG_COUNT_CODE;      // RULE_13
        msi_cap_v.msg_count_enabled     = MSG_COUNT_CODE;      // RULE_13
        msi_cap_v.wide_address_capable  = 1'b1;                // RULE_14
    end

    // Returns the read image of a register and whether the index is mapped.
    function automatic logic [32:0] read_word(input logic [IDX_W-1:0] idx);
        logic [32:0] res;
        res = '0;
        unique case (idx)
            IDX_LINK_CAP:    res = {1'b1, link_cap_v};
            IDX_LINK_CTRL:   res = {1'b1, 16'h0000, link_ctrl_v};
            IDX_LINK_STATUS: res = {1'b1, 16'h0000, link_status_v};
            IDX_MSI_CAP:     res = {1'b1, msi_cap_v};
            IDX_MSI_ADDR_LO: res = {1'b1, addr_dw_q, 2'h0};              // RULE_15
            IDX_MSI_ADDR_HI: res = {1'b1, addr_high_q};
            IDX_MSI_DATA:    res = {1'b1, 16'h0000, payload_q};          // RULE_17
            IDX_BRIDGE_CAP:  res = {1'b1, bridge_q};
            default:         res = '0;
        endcase
        return res;
    endfunction

    // Merges write data into the current image under the byte strobes.
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    assign aw_take  = awvalid && awready_q;
    assign w_take   = wvalid && wready_q;
    assign do_write = aw_held_q && w_held_q && !bvalid_q;
    assign ar_take  = arvalid && arready_q;
    assign ar_idx   = araddr[ADDR_W-1:2];

    always_comb begin
        {cur_hit, cur_word} = read_word(aw_idx_q);
        new_word            = merge(cur_word, wdata_q, wstrb_q);
        new_ctrl            = link_ctrl_s'(new_word[15:0]);
        new_msi             = msi_cap_s'(new_word);
        {rd_hit, rd_word}   = read_word(ar_idx);
    end

    // Write address channel: one address held until its write completes.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held_q <= 1'b0;
            aw_idx_q  <= '0;
            awready_q <= 1'b0;
        end else begin
            if (do_write) begin
                aw_held_q <= 1'b0;
                awready_q <= 1'b1;
            end else if (aw_take) begin
                aw_held_q <= 1'b1;
                aw_idx_q  <= awaddr[ADDR_W-1:2];
                awready_q <= 1'b0;
            end else begin
                awready_q <= !aw_held_q;
            end
        end
    end

    // Write data channel: one beat held until its write completes.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            w_held_q <= 1'b0;
            wdata_q  <= '0;
            wstrb_q  <= '0;
            wready_q <= 1'b0;
        end else begin
            if (do_write) begin
                w_held_q <= 1'b0;
                wready_q <= 1'b1;
            end else if (w_take) begin
                w_held_q <= 1'b1;
                wdata_q  <= wdata;
                wstrb_q  <= wstrb;
                wready_q <= 1'b0;
            end else begin
                wready_q <= !w_held_q;
            end
        end
    end

    // Write response: an unmapped index answers with a slave error.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end else begin
            if (do_write) begin
                bvalid_q <= 1'b1;
                bresp_q  <= cur_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Read channel: the data is captured on the address edge.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= '0;
            rresp_q   <= RESP_OKAY;
        end else begin
            if (ar_take) begin
                arready_q <= 1'b0;
                rvalid_q  <= 1'b1;
                rdata_q   <= rd_word;
                rresp_q   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (rvalid_q && rready) begin
                rvalid_q  <= 1'b0;
                arready_q <= 1'b1;
            end else begin
                arready_q <= !rvalid_q;
            end
        end
    end

    // Link control storage; the other link control bits are fixed.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            power_ctrl_q <= 2'h0;
            refclk_cfg_q <= 1'b0;
            long_sync_q  <= 1'b0;
        end else if (do_write && aw_idx_q == IDX_LINK_CTRL) begin
            power_ctrl_q <= new_ctrl.power_state_ctrl;   // RULE_06
            refclk_cfg_q <= new_ctrl.shared_refclk_cfg;  // RULE_08
            long_sync_q  <= new_ctrl.long_sync_bit;      // RULE_08
        end
    end

    // Interrupt enable.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            msi_enable_q <= 1'b0;
        end else if (do_write && aw_idx_q == IDX_MSI_CAP) begin
            msi_enable_q <= new_msi.msi_enable;  // RULE_12
        end
    end

    // Interrupt address and message data.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            addr_dw_q   <= '0;
            addr_high_q <= '0;
            payload_q   <= '0;
        end else if (do_write) begin
            if (aw_idx_q == IDX_MSI_ADDR_LO) begin
                addr_dw_q <= new_word[31:2];  // RULE_15
            end
            if (aw_idx_q == IDX_MSI_ADDR_HI) begin
                addr_high_q <= new_word;
            end
            if (aw_idx_q == IDX_MSI_DATA) begin
                payload_q <= new_word[15:0];  // RULE_17
            end
        end
    end

    // Bridge capability header, fully writable.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bridge_q.vendor_cap_identifier <= VENDOR_CAP_ID_RST;    // RULE_18
            bridge_q.next_cap_pointer      <= BRIDGE_NEXT_PTR_RST;  // RULE_19
            bridge_q.cap_length            <= CAP_LENGTH_RST;
            bridge_q.cap_kind              <= CAP_KIND_RST;
        end else if (do_write && aw_idx_q == IDX_BRIDGE_CAP) begin
            bridge_q <= bridge_cap_s'(new_word);  // RULE_18 RULE_19
        end
    end

    assign launch = (msi_state_q == MSI_IDLE) && pending_q && msi_enable_q;

    // Pending event: a new event wins over the clear at launch.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pending_q <= 1'b0;
        end else if (!msi_enable_q) begin
            pending_q <= 1'b0;  // RULE_20
        end else if (irq_event) begin
            pending_q <= 1'b1;  // RULE_20
        end else if (launch) begin
            pending_q <= 1'b0;
        end
    end

    // Message sender: one write per pending event, held until acknowledged.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            msi_state_q <= MSI_IDLE;
            msi_valid_q <= 1'b0;
            msi_req_q   <= '0;
        end else begin
            unique case (msi_state_q)
                MSI_IDLE: begin
                    if (launch) begin
                        msi_valid_q             <= 1'b1;  // RULE_20
                        msi_req_q.wide          <= (addr_high_q != '0);  // RULE_16
                        msi_req_q.msg_addr_high <= addr_high_q;  // RULE_16
                        msi_req_q.msg_addr_low  <= {addr_dw_q, 2'h0};
                        msi_req_q.data          <= {16'h0000, payload_q};  // RULE_17
                        msi_state_q             <= MSI_SEND;
                    end
                end
                MSI_SEND: begin
                    if (msi_req_ack) begin
                        msi_valid_q <= 1'b0;
                        msi_state_q <= MSI_IDLE;
                    end
                end
            endcase
        end
    end

    assign awready          = awready_q;
    assign wready           = wready_q;
    assign bvalid           = bvalid_q;
    assign bresp            = bresp_q;
    assign arready          = arready_q;
    assign rvalid           = rvalid_q;
    assign rdata            = rdata_q;
    assign rresp            = rresp_q;
    assign msi_req          = msi_req_q;
    assign msi_req_valid    = msi_valid_q;
    assign msi_enable       = msi_enable_q;
    assign power_state_ctrl = power_ctrl_q;

endmodule

// >>> ntb_link_msi_pkg.sv
// Purpose: Constants, field layouts and carriers for the link and message interrupt registers.
// Assumes: AXI4-Lite access, 32-bit data, one aligned word per register index.
// Notes: Byte address of a register is four times its index.
// Function
// (RULE_01) Link capabilities 3:0 read 0x1, maximum speed 2.5 Gbps, writes ignored.
// (RULE_02) Link capabilities 9:4 read constant 0x8 maximum width, read-only.
// (RULE_03) Link capabilities 11:10 read 0x1, light sleep entry advertised only.
// (RULE_04) Both exit latency fields, bits 14:12 and 17:15, read zero.
// (RULE_05) Port index bits 31:24 and bits 23:18 read zero.
// (RULE_06) Link control 1:0 writable power state control, resets to zero.
// (RULE_07) Link control bits 3, 4 and 5 read-only zero.
// (RULE_08) Link control bits 6 and 7 writable storage, reset zero, no effect.
// (RULE_09) Link status reads speed 0x1 in 3:0 and width 0x8 in 9:4.
// (RULE_10) Link status bits 15:10 always read zero and ignore writes.
// (RULE_11) Interrupt capability header reads identifier 0x5 and next pointer 0x74.
// (RULE_12) Interrupt capability bit 16 is writable enable, resets to zero.
// (RULE_13) One message only: bits 19:17 and 22:20 read zero.
// (RULE_14) Bit 23 reads one for wide address support; bits 31:24 read zero.
// (RULE_15) Lower address stores bits 31:2, resets zero; bits 1:0 read zero.
// (RULE_16) Nonzero upper address selects a wide interrupt write, zero selects narrow.
// (RULE_17) Message data 15:0 writable, reset zero, low half of each write.
// (RULE_18) Bridge header identifier 7:0 writable, resets to 0x9.
// (RULE_19) Bridge header next pointer 15:8 writable, resets to 0xb4.
// (RULE_20) With enable set each event sends one write; nothing while enable clear. Events arriving while a write is outstanding merge into one more write.
package ntb_link_msi_pkg;

    localparam int unsigned ADDR_W = 12;
    localparam int unsigned IDX_W  = 10;

    localparam logic [IDX_W-1:0] IDX_LINK_CAP    = 10'h04c;
    localparam logic [IDX_W-1:0] IDX_LINK_CTRL   = 10'h050;
    localparam logic [IDX_W-1:0] IDX_LINK_STATUS = 10'h052;
    localparam logic [IDX_W-1:0] IDX_MSI_CAP     = 10'h064;
    localparam logic [IDX_W-1:0] IDX_MSI_ADDR_LO = 10'h068;
    localparam logic [IDX_W-1:0] IDX_MSI_ADDR_HI = 10'h06c;
    localparam logic [IDX_W-1:0] IDX_MSI_DATA    = 10'h070;
    localparam logic [IDX_W-1:0] IDX_BRIDGE_CAP  = 10'h074;

    localparam logic [3:0] SPEED_CODE          = 4'h1;
    localparam logic [5:0] WIDTH_CODE          = 6'h08;
    localparam logic [1:0] POWER_SUPPORT_CODE  = 2'h1;
    localparam logic [2:0] EXIT_LAT_CODE       = 3'h0;
    localparam logic [7:0] PORT_INDEX_CODE     = 8'h00;
    localparam logic [7:0] MSI_CAP_ID          = 8'h05;
    localparam logic [7:0] MSI_NEXT_PTR        = 8'h74;
    localparam logic [2:0] MSG_COUNT_CODE      = 3'h0;
    localparam logic [7:0] VENDOR_CAP_ID_RST   = 8'h09;
    localparam logic [7:0] BRIDGE_NEXT_PTR_RST = 8'hb4;
    localparam logic [7:0] CAP_LENGTH_RST      = 8'h40;
    localparam logic [7:0] CAP_KIND_RST        = 8'h01;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [7:0] port_index;
        logic [5:0] rsvd;
        logic [2:0] deep_sleep_exit_lat;
        logic [2:0] light_sleep_exit_lat;
        logic [1:0] power_state_support;
        logic [5:0] max_width_code;
        logic [3:0] max_speed_code;
    } link_cap_s;

    typedef struct packed {
        logic [7:0] rsvd_hi;
        logic       long_sync_bit;
        logic       shared_refclk_cfg;
        logic       retrain_bit;
        logic       link_off_bit;
        logic       completion_boundary;
        logic       rsvd_lo;
        logic [1:0] power_state_ctrl;
    } link_ctrl_s;

    typedef struct packed {
        logic [2:0] rsvd;
        logic       slot_clock_cfg;
        logic       training_flag;
        logic       train_fault_flag;
        logic [5:0] current_width_code;
        logic [3:0] current_speed_code;
    } link_status_s;

    typedef struct packed {
        logic [7:0] rsvd;
        logic       wide_address_capable;
        logic [2:0] msg_count_enabled;
        logic [2:0] msg_count_capable;
        logic       msi_enable;
        logic [7:0] next_cap_pointer;
        logic [7:0] cap_identifier;
    } msi_cap_s;

    typedef struct packed {
        logic [7:0] cap_kind;
        logic [7:0] cap_length;
        logic [7:0] next_cap_pointer;
        logic [7:0] vendor_cap_identifier;
    } bridge_cap_s;

    typedef struct packed {
        logic        wide;
        logic [31:0] msg_addr_high;
        logic [31:0] msg_addr_low;
        logic [31:0] data;
    } msi_req_s;

endpackage

// >>> tb_top.sv
// Purpose: Bench for the link and message interrupt registers.
// Assumes: AXI4-Lite master tasks and the interrupt sink model.
// Notes: Byte address is four times the register index.
`timescale 1ns/1ns
module tb_top
    import ntb_link_msi_pkg::*;
;
    localparam logic [11:0] A_CAP  = {IDX_LINK_CAP, 2'h0};
    localparam logic [11:0] A_CTL  = {IDX_LINK_CTRL, 2'h0};
    localparam logic [11:0] A_STS  = {IDX_LINK_STATUS, 2'h0};
    localparam logic [11:0] A_MCAP = {IDX_MSI_CAP, 2'h0};
    localparam logic [11:0] A_ALO  = {IDX_MSI_ADDR_LO, 2'h0};
    localparam logic [11:0] A_AHI  = {IDX_MSI_ADDR_HI, 2'h0};
    localparam logic [11:0] A_DAT  = {IDX_MSI_DATA, 2'h0};
    localparam logic [11:0] A_BRG  = {IDX_BRIDGE_CAP, 2'h0};
    localparam logic [11:0] REGS [8] = '{A_CAP, A_CTL, A_STS, A_MCAP, A_ALO, A_AHI, A_DAT, A_BRG};
    localparam logic [1:0]  OK = RESP_OKAY;

    logic        mclk = 1'h0, rst_n = 1'h0, irq_event = 1'h0, slow = 1'h0;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [11:0] awaddr = 12'h0, araddr = 12'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0]  wstrb = 4'h0;
    logic        awready, wready, bvalid, arready, rvalid, msi_req_valid, msi_req_ack, msi_enable;
    logic [1:0]  bresp, rresp, power_state_ctrl;
    msi_req_s    msi_req, last_req;
    int          req_count, fail_count = 0, tests_run = 0;

    always #25 mclk = ~mclk;
    ntb_link_msi_cap_regs u_ntb_link_msi_cap_regs (
        .mclk(mclk), .rst_n(rst_n), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .irq_event(irq_event), .msi_req(msi_req),
        .msi_req_valid(msi_req_valid), .msi_req_ack(msi_req_ack), .msi_enable(msi_enable),
        .power_state_ctrl(power_state_ctrl)
    );
    msi_sink_model u_msi_sink_model (
        .mclk(mclk), .rst_n(rst_n), .msi_req(msi_req), .msi_req_valid(msi_req_valid),
        .slow(slow), .msi_req_ack(msi_req_ack), .last_req(last_req), .req_count(req_count)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        @(posedge mclk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'h1;
        wvalid  <= 1'h1;
        bready  <= 1'h1;
        do begin
            @(posedge mclk);
            if (awready === 1'h1) awvalid <= 1'h0;
            if (wready === 1'h1) wvalid <= 1'h0;
        end while (bvalid !== 1'h1);
        bready <= 1'h0;
        chk({30'h0, bresp}, {30'h0, er});
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge mclk);
        araddr  <= a;
        arvalid <= 1'h1;
        rready  <= 1'h1;
        do begin
            @(posedge mclk);
            if (arready === 1'h1) arvalid <= 1'h0;
        end while (rvalid !== 1'h1);
        rready <= 1'h0;
        chk(rdata, ed);
        chk({30'h0, rresp}, {30'h0, er});
    endtask

    task automatic pulse;
        @(posedge mclk);
        irq_event <= 1'h1;
        @(posedge mclk);
        irq_event <= 1'h0;
    endtask

    task automatic test_done;
        $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge mclk);
        fail_count++;
        test_done;
    end

    initial begin
        repeat (16) @(posedge mclk);
        rst_n <= 1'h1;
        rd(A_CAP, 32'h00000481, OK);
        rd(A_CTL, 32'h00000000, OK);
        rd(A_STS, 32'h00000081, OK);
        rd(A_MCAP, 32'h00807405, OK);
        rd(A_ALO, 32'h00000000, OK);
        rd(A_AHI, 32'h00000000, OK);
        rd(A_DAT, 32'h00000000, OK);
        rd(A_BRG, 32'h0140b409, OK);
        for (int i = 0; i < 8; i++) wr(REGS[i], 32'hffffffff, 4'hf, OK);
        rd(A_CAP, 32'h00000481, OK);
        rd(A_CTL, 32'h000000c3, OK);
        chk({30'h0, power_state_ctrl}, 32'h3);
        rd(A_STS, 32'h00000081, OK);
        rd(A_MCAP, 32'h00817405, OK);
        chk({31'h0, msi_enable}, 32'h1);
        rd(A_ALO, 32'hfffffffc, OK);
        rd(A_AHI, 32'hffffffff, OK);
        rd(A_DAT, 32'h0000ffff, OK);
        rd(A_BRG, 32'hffffffff, OK);
        wr(A_CTL, 32'h00000041, 4'hf, OK);
        rd(A_CTL, 32'h00000041, OK);
        chk({30'h0, power_state_ctrl}, 32'h1);
        wr(A_BRG, 32'h12343c5a, 4'h3, OK);
        rd(A_BRG, 32'hffff3c5a, OK);
        wr(12'h000, 32'hffffffff, 4'hf, RESP_SLVERR);
        rd(12'h144, 32'h00000000, RESP_SLVERR);
        wr(A_ALO, 32'h10000003, 4'hf, OK);
        wr(A_AHI, 32'h00000000, 4'hf, OK);
        wr(A_DAT, 32'habcd1234, 4'hf, OK);
        pulse;
        while (req_count != 1) @(posedge mclk);
        chk({31'h0, last_req.wide}, 32'h0);
        chk(last_req.msg_addr_low, 32'h10000000);
        chk(last_req.data, 32'h00001234);
        wr(A_AHI, 32'h00000002, 4'hf, OK);
        pulse;
        while (req_count != 2) @(posedge mclk);
        chk({31'h0, last_req.wide}, 32'h1);
        chk(last_req.msg_addr_high, 32'h00000002);
        slow <= 1'h1;
        repeat (3) pulse;
        repeat (20) @(posedge mclk);
        chk(req_count, 32'h4);
        slow <= 1'h0;
        wr(A_MCAP, 32'h00000000, 4'hf, OK);
        chk({31'h0, msi_enable}, 32'h0);
        pulse;
        repeat (8) @(posedge mclk);
        chk(req_count, 32'h4);
        rst_n <= 1'h0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'h1;
        rd(A_CTL, 32'h00000000, OK);
        rd(A_ALO, 32'h00000000, OK);
        rd(A_BRG, 32'h0140b409, OK);
        test_done;
    end
endmodule
